//--- uprog_pkg.sv
// constants and carrier types of the user program object bank
package uprog_pkg;
	// ------------------------------------------------------------
	// object indices
	// ------------------------------------------------------------
	localparam logic [15:0] UPROG_IDX_INPUT = 16'h2400;
	localparam logic [15:0] UPROG_IDX_INIT = 16'h2410;
	localparam logic [15:0] UPROG_IDX_OUTPUT = 16'h2500;
	localparam logic [15:0] UPROG_IDX_DEBUG = 16'h2600;
	localparam logic [15:0] UPROG_IDX_CUST = 16'h2701;
	localparam logic [15:0] UPROG_IDX_BOOT = 16'h2800;
	localparam logic [15:0] UPROG_IDX_SUBMODE = 16'h3202;
	// ------------------------------------------------------------
	// highest subindices and sizes
	// ------------------------------------------------------------
	localparam logic [7:0] UPROG_SUB_COUNT = 8'h00;
	localparam logic [7:0] UPROG_MBOX_MAX = 8'h20;
	localparam logic [7:0] UPROG_DEBUG_MAX = 8'h40;
	localparam logic [7:0] UPROG_CUST_MAX = 8'hFE;
	localparam logic [7:0] UPROG_BOOT_MAX = 8'h03;
	localparam logic [7:0] UPROG_BOOT_CMD = 8'h01;
	localparam logic [7:0] UPROG_BOOT_DELAY = 8'h02;
	localparam logic [7:0] UPROG_BOOT_HWCFG = 8'h03;
	localparam int UPROG_MBOX_WORDS = 32;
	localparam int UPROG_DEBUG_BYTES = 64;
	localparam int UPROG_CUST_WORDS = 254;
	// ------------------------------------------------------------
	// values and fields
	// ------------------------------------------------------------
	localparam logic [31:0] UPROG_REBOOT_MAGIC = 32'h746F6F62;
	localparam logic [31:0] UPROG_WORD_RESET = 32'h00000000;
	localparam logic [7:0] UPROG_BYTE_RESET = 8'h00;
	localparam int UPROG_HWCFG_NOSHORT_BIT = 0;
	localparam int UPROG_SUBMODE_CLOSED_BIT = 0;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int UPROG_CLK_PERIOD_PS = 5000;
	localparam int UPROG_MS_PS = 1000000000;
	localparam int UPROG_CYCLES_PER_MS = UPROG_MS_PS / UPROG_CLK_PERIOD_PS;
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] index;
		logic [7:0] sub;
		logic [31:0] wdata;
	} uprog_od_req_type;
	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} uprog_od_rsp_type;
	typedef struct packed {
		logic valid;
		logic to_debug;
		logic [7:0] addr;
		logic [31:0] wdata;
	} uprog_up_wr_type;
endpackage

//--- uprog_ms_delay.sv
// millisecond delay timer for the commanded reboot
`timescale 1ns/1ps
`default_nettype none
module uprog_ms_delay
	import uprog_pkg::*;
#(
	parameter int CYCLES_PER_MS = UPROG_CYCLES_PER_MS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [31:0] delay_ms,
	output logic fire_r
);
	typedef enum logic [1:0] {
		UPROG_T_IDLE = 2'b01,
		UPROG_T_WAIT = 2'b10
	} uprog_tstate_type;

	localparam logic [31:0] CYC_LAST = 32'(CYCLES_PER_MS - 1);

	uprog_tstate_type state_r, state_nxt;
	logic [31:0] cyc_r, cyc_nxt;
	logic [31:0] ms_r, ms_nxt;
	logic fire_nxt;

	// ----------------------------------------------------------------
	// countdown of whole milliseconds, restart on a new command
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		cyc_nxt = cyc_r;
		ms_nxt = ms_r;
		fire_nxt = 1'b0;
		case (state_r)
			UPROG_T_IDLE: begin
				if (start) begin
					state_nxt = UPROG_T_WAIT;
					cyc_nxt = '0;
					ms_nxt = delay_ms;
				end
			end
			UPROG_T_WAIT: begin
				if (start) begin
					cyc_nxt = '0;
					ms_nxt = delay_ms;
				end else if (ms_r == '0) begin
					fire_nxt = 1'b1; // delay spent
					state_nxt = UPROG_T_IDLE;
				end else if (cyc_r == CYC_LAST) begin
					cyc_nxt = '0;
					ms_nxt = ms_r - 32'h00000001;
				end else begin
					cyc_nxt = cyc_r + 32'h00000001;
				end
			end
			default: begin
				state_nxt = UPROG_T_IDLE;
			end
		endcase
	end

	// state registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= UPROG_T_IDLE;
			cyc_r <= '0;
			ms_r <= '0;
			fire_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cyc_r <= cyc_nxt;
			ms_r <= ms_nxt;
			fire_r <= fire_nxt;
		end
	end
endmodule
`default_nettype wire

//--- uprog_bank.sv
// user program object bank: mailboxes, debug buffer, storage, reboot, submode
//
// How it works
// - outputs array holds 32 signed words, only carried, never interpreted.
// - subindex zero of each mailbox is read-only, reports 20h.
// - init array behaves like inputs, stored for application save.
// - init entries are read/write and writable by mapped process data.
// - user program writes outputs; master reads them.
// - 64 read-only debug bytes filled by program print calls, reset zero.
// - 254 read/write customer storage words, reset zero.
// - only value 746F6F62h written to reboot command starts a reboot.
// - reboot waits the number of milliseconds in the delay entry.
// - hardware config bit 0 set: no winding short in bootloader.
// - submode word selects closed/open loop and velocity emulation; only bit 0, loop closure, is decoded here.
// - loop closure bit zero is open loop, one closed loop.
`timescale 1ns/1ps
`default_nettype none
module uprog_bank
	import uprog_pkg::*;
#(
	parameter int CYCLES_PER_MS = UPROG_CYCLES_PER_MS,
	parameter logic [31:0] SUBMODE_RESET = 32'h00000000
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire uprog_od_req_type od_req,
	output uprog_od_rsp_type od_rsp_r,
	input wire uprog_up_wr_type up_wr,
	input wire logic up_rd_init,
	input wire logic [4:0] up_rd_addr,
	output logic [31:0] up_rdata_r,
	input wire logic bootloader_mode,
	output logic windings_short_r,
	output logic reboot_r,
	output logic [31:0] submode_r,
	output logic loop_closed_r
);
	logic [31:0] in_mem [UPROG_MBOX_WORDS];
	logic [31:0] init_mem [UPROG_MBOX_WORDS];
	logic [31:0] out_mem [UPROG_MBOX_WORDS];
	logic [7:0] dbg_mem [UPROG_DEBUG_BYTES];
	logic [31:0] cust_mem [UPROG_CUST_WORDS];
	logic [31:0] boot_cmd_r, boot_delay_r, boot_cfg_r;
	logic [31:0] boot_cmd_nxt, boot_delay_nxt, boot_cfg_nxt, submode_nxt;
	uprog_od_rsp_type rsp_nxt;
	logic [31:0] up_rdata_nxt;
	logic in_we, init_we, cust_we, reboot_start;
	logic [7:0] slot;
	logic wr;
	logic reboot_fire;
	logic short_nxt, closed_nxt;

	// ----------------------------------------------------------------
	// object decode, read mux and write enables
	// ----------------------------------------------------------------
	always_comb begin
		slot = od_req.sub - 8'h01;
		wr = od_req.valid & od_req.write;
		rsp_nxt = '0;
		rsp_nxt.ack = od_req.valid;
		in_we = 1'b0;
		init_we = 1'b0;
		cust_we = 1'b0;
		reboot_start = 1'b0;
		boot_cmd_nxt = boot_cmd_r;
		boot_delay_nxt = boot_delay_r;
		boot_cfg_nxt = boot_cfg_r;
		submode_nxt = submode_r;
		case (od_req.index)
			UPROG_IDX_INPUT, UPROG_IDX_INIT: begin
				if (od_req.sub == UPROG_SUB_COUNT) begin
					rsp_nxt.rdata = {24'h000000, UPROG_MBOX_MAX};
					rsp_nxt.err = od_req.write;
				end else if (od_req.sub <= UPROG_MBOX_MAX) begin
					if (od_req.index == UPROG_IDX_INPUT) begin
						rsp_nxt.rdata = in_mem[slot[4:0]];
						in_we = wr;
					end else begin
						rsp_nxt.rdata = init_mem[slot[4:0]];
						init_we = wr;
					end
				end else begin
					rsp_nxt.err = 1'b1;
				end
			end
			UPROG_IDX_OUTPUT: begin
				if (od_req.sub == UPROG_SUB_COUNT) begin
					rsp_nxt.rdata = {24'h000000, UPROG_MBOX_MAX};
					rsp_nxt.err = od_req.write;
				end else if (od_req.sub <= UPROG_MBOX_MAX) begin
					rsp_nxt.rdata = out_mem[slot[4:0]];
					rsp_nxt.err = od_req.write;
				end else begin
					rsp_nxt.err = 1'b1;
				end
			end
			UPROG_IDX_DEBUG: begin
				if (od_req.sub == UPROG_SUB_COUNT) begin
					rsp_nxt.rdata = {24'h000000, UPROG_DEBUG_MAX};
					rsp_nxt.err = od_req.write;
				end else if (od_req.sub <= UPROG_DEBUG_MAX) begin
					rsp_nxt.rdata = {24'h000000, dbg_mem[slot[5:0]]};
					rsp_nxt.err = od_req.write;
				end else begin
					rsp_nxt.err = 1'b1;
				end
			end
			UPROG_IDX_CUST: begin
				if (od_req.sub == UPROG_SUB_COUNT) begin
					rsp_nxt.rdata = {24'h000000, UPROG_CUST_MAX};
					rsp_nxt.err = od_req.write;
				end else if (od_req.sub <= UPROG_CUST_MAX) begin
					rsp_nxt.rdata = cust_mem[slot];
					cust_we = wr;
				end else begin
					rsp_nxt.err = 1'b1;
				end
			end
			UPROG_IDX_BOOT: begin
				case (od_req.sub)
					UPROG_SUB_COUNT: begin
						rsp_nxt.rdata = {24'h000000, UPROG_BOOT_MAX};
						rsp_nxt.err = od_req.write;
					end
					UPROG_BOOT_CMD: begin
						rsp_nxt.rdata = boot_cmd_r;
						if (wr) begin
							boot_cmd_nxt = od_req.wdata;
							reboot_start = (od_req.wdata == UPROG_REBOOT_MAGIC);
						end
					end
					UPROG_BOOT_DELAY: begin
						rsp_nxt.rdata = boot_delay_r;
						if (wr) begin
							boot_delay_nxt = od_req.wdata;
						end
					end
					UPROG_BOOT_HWCFG: begin
						rsp_nxt.rdata = boot_cfg_r;
						if (wr) begin
							boot_cfg_nxt = od_req.wdata;
						end
					end
					default: begin
						rsp_nxt.err = 1'b1;
					end
				endcase
			end
			UPROG_IDX_SUBMODE: begin
				if (od_req.sub == UPROG_SUB_COUNT) begin
					rsp_nxt.rdata = submode_r;
					if (wr) begin
						submode_nxt = od_req.wdata;
					end
				end else begin
					rsp_nxt.err = 1'b1;
				end
			end
			default: begin
				rsp_nxt.err = 1'b1;
			end
		endcase
		if (!od_req.valid) begin
			rsp_nxt = '0;
		end
		up_rdata_nxt = up_rd_init ? init_mem[up_rd_addr] : in_mem[up_rd_addr];
		short_nxt = bootloader_mode & ~boot_cfg_r[UPROG_HWCFG_NOSHORT_BIT];
		closed_nxt = submode_r[UPROG_SUBMODE_CLOSED_BIT];
	end

	// ----------------------------------------------------------------
	// mailbox and storage arrays
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < UPROG_MBOX_WORDS; i++) begin
				in_mem[i] <= UPROG_WORD_RESET;
				init_mem[i] <= UPROG_WORD_RESET;
				out_mem[i] <= UPROG_WORD_RESET;
			end
			for (int i = 0; i < UPROG_DEBUG_BYTES; i++) begin
				dbg_mem[i] <= UPROG_BYTE_RESET;
			end
			for (int i = 0; i < UPROG_CUST_WORDS; i++) begin
				cust_mem[i] <= UPROG_WORD_RESET;
			end
		end else begin
			if (in_we) begin
				in_mem[slot[4:0]] <= od_req.wdata;
			end
			if (init_we) begin
				init_mem[slot[4:0]] <= od_req.wdata;
			end
			if (cust_we) begin
				cust_mem[slot] <= od_req.wdata;
			end
			if (up_wr.valid && !up_wr.to_debug) begin
				out_mem[up_wr.addr[4:0]] <= up_wr.wdata;
			end
			if (up_wr.valid && up_wr.to_debug) begin
				dbg_mem[up_wr.addr[5:0]] <= up_wr.wdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// control words and registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			od_rsp_r <= '0;
			up_rdata_r <= UPROG_WORD_RESET;
			boot_cmd_r <= UPROG_WORD_RESET;
			boot_delay_r <= UPROG_WORD_RESET;
			boot_cfg_r <= UPROG_WORD_RESET;
			submode_r <= SUBMODE_RESET;
			windings_short_r <= 1'b0;
			loop_closed_r <= 1'b0;
			reboot_r <= 1'b0;
		end else begin
			od_rsp_r <= rsp_nxt;
			up_rdata_r <= up_rdata_nxt;
			boot_cmd_r <= boot_cmd_nxt;
			boot_delay_r <= boot_delay_nxt;
			boot_cfg_r <= boot_cfg_nxt;
			submode_r <= submode_nxt;
			windings_short_r <= short_nxt;
			loop_closed_r <= closed_nxt;
			reboot_r <= reboot_fire;
		end
	end

	// reboot delay in whole milliseconds
	uprog_ms_delay #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) u_delay (
		.clock(clock),
		.rst_n(rst_n),
		.start(reboot_start),
		.delay_ms(boot_delay_r),
		.fire_r(reboot_fire)
	);
endmodule
`default_nettype wire

//--- uprog_bank_monitor.sv
// assertion checker for the user program object bank ports
`timescale 1ns/1ps
`default_nettype none
module uprog_bank_monitor
	import uprog_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire uprog_od_req_type od_req,
	input wire uprog_od_rsp_type od_rsp_r,
	input wire logic bootloader_mode,
	input wire logic windings_short_r,
	input wire logic reboot_r,
	input wire logic [31:0] submode_r,
	input wire logic loop_closed_r
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// answers: one ack per request, quiet otherwise
	a_ack_each_req: assert property (od_req.valid |=> od_rsp_r.ack) else $error("ack missing");
	a_quiet_idle: assert property (!od_req.valid |=> !od_rsp_r.ack && od_rsp_r.rdata == 32'h0)
		else $error("answer without request");
	// access kinds
	a_sub0_count: assert property (od_req.valid && !od_req.write && od_req.sub == 8'h00 &&
		od_req.index == UPROG_IDX_INPUT |=> od_rsp_r.rdata == 32'h20 && !od_rsp_r.err)
		else $error("bad count");
	a_sub0_ro: assert property (od_req.valid && od_req.write && od_req.sub == 8'h00 &&
		od_req.index == UPROG_IDX_INIT |=> od_rsp_r.err) else $error("count written");
	a_out_ro: assert property (od_req.valid && od_req.write && od_req.index == UPROG_IDX_OUTPUT
		|=> od_rsp_r.err) else $error("output written");
	a_debug_ro: assert property (od_req.valid && od_req.write && od_req.index == UPROG_IDX_DEBUG
		|=> od_rsp_r.err) else $error("debug written");
	a_store_limit: assert property (od_req.valid && od_req.index == UPROG_IDX_CUST &&
		od_req.sub == 8'hFF |=> od_rsp_r.err) else $error("storage limit");
	// side effects
	a_reboot_pulse: assert property (reboot_r |=> !reboot_r) else $error("reboot held");
	a_windings_off: assert property (!$past(bootloader_mode) |-> !windings_short_r)
		else $error("short outside loader");
	a_submode_word: assert property (od_req.valid && od_req.write &&
		od_req.index == UPROG_IDX_SUBMODE && od_req.sub == 8'h00
		|=> submode_r == $past(od_req.wdata)) else $error("submode lost");
	a_loop_bit: assert property ($stable(submode_r) |-> loop_closed_r == submode_r[0])
		else $error("loop bit");
endmodule
`default_nettype wire

//--- uprog_user_prog.sv
// user program model: writes outputs and debug bytes, reads mailboxes
`timescale 1ns/1ps
`default_nettype none
module uprog_user_prog
	import uprog_pkg::*;
(
	input wire logic clock,
	output uprog_up_wr_type up_wr,
	output logic up_rd_init,
	output logic [4:0] up_rd_addr,
	input wire logic [31:0] up_rdata_r
);
	// idle program at time zero
	initial begin
		up_wr = '0;
		up_rd_init = 1'b0;
		up_rd_addr = 5'h00;
	end
	// one write pulse, held for exactly one edge
	task automatic put(input logic dbg, input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		up_wr <= '{1'b1, dbg, a, v};
		@(posedge clock);
		up_wr.valid <= 1'b0;
	endtask
	// slot read, word stands one cycle after the address
	task automatic get(input logic init, input logic [4:0] a, output logic [31:0] v);
		@(posedge clock);
		up_rd_init <= init;
		up_rd_addr <= a;
		repeat (2) @(posedge clock);
		#1 v = up_rdata_r;
	endtask
endmodule
`default_nettype wire

//--- uprog_bank_test.sv
// self-checking bench of the user program object bank
`timescale 1ns/1ps
`default_nettype none
module uprog_bank_test
	import uprog_pkg::*;
;
	localparam int CPM = 4;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic boot = 1'b0;
	uprog_od_req_type req = '0;
	uprog_od_rsp_type rsp;
	uprog_up_wr_type upw;
	logic ri, shrt, reboot, loop, e;
	logic [4:0] ra;
	logic [31:0] urd, smode, d;
	int fail_count = 0;
	int n_checks = 0;
	int n;
	logic [15:0] idx [6] = '{UPROG_IDX_INPUT, UPROG_IDX_INIT, UPROG_IDX_OUTPUT,
		UPROG_IDX_DEBUG, UPROG_IDX_CUST, UPROG_IDX_BOOT};
	logic [7:0] cnt [6] = '{8'h20, 8'h20, 8'h20, 8'h40, 8'hFE, 8'h03};
	always #2.5 clock = ~clock;
	uprog_bank #(.CYCLES_PER_MS(CPM)) dut (.clock(clock), .rst_n(rst_n), .od_req(req),
		.od_rsp_r(rsp), .up_wr(upw), .up_rd_init(ri), .up_rd_addr(ra), .up_rdata_r(urd),
		.bootloader_mode(boot), .windings_short_r(shrt), .reboot_r(reboot),
		.submode_r(smode), .loop_closed_r(loop));
	uprog_user_prog prog (.clock(clock), .up_wr(upw), .up_rd_init(ri), .up_rd_addr(ra),
		.up_rdata_r(urd));
	// ------------------------------------------------------------
	// checking and access tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one request, one edge of valid, bounded wait for ack
	task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] v);
		int k;
		@(posedge clock);
		req <= '{1'b1, w, i, s, v};
		@(posedge clock);
		req.valid <= 1'b0;
		#1 k = 0;
		while (rsp.ack !== 1'b1 && k < 4) begin
			@(posedge clock);
			#1 k++;
		end
		if (k == 4) begin
			fail_count++;
			summarize();
		end
		e = rsp.err;
		d = rsp.rdata;
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
		od(1'b0, i, s, 32'h0);
		check(d, x);
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] v, input logic x);
		od(1'b1, i, s, v);
		check({31'h0, e}, {31'h0, x});
	endtask
	task automatic watch();
		for (n = 0; n < 40 && reboot !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		for (int j = 0; j < 6; j++) begin
			rd(idx[j], 8'h00, {24'h0, cnt[j]});
			rd(idx[j], cnt[j], 32'h0);
			wr(idx[j], 8'h00, 32'h5A, 1'b1);
			wr(idx[j], cnt[j] + 8'h01, 32'h5A, 1'b1);
			rd(idx[j], 8'h00, {24'h0, cnt[j]});
		end
		wr(UPROG_IDX_OUTPUT, 8'h01, 32'h7, 1'b1);
		wr(UPROG_IDX_DEBUG, 8'h01, 32'h7, 1'b1);
		wr(16'h2401, 8'h01, 32'h7, 1'b1);
		wr(UPROG_IDX_INPUT, 8'h05, 32'hFFFFFFFB, 1'b0);
		prog.get(1'b0, 5'h04, d);
		check(d, 32'hFFFFFFFB);
		wr(UPROG_IDX_INIT, 8'h20, 32'h12345678, 1'b0);
		rd(UPROG_IDX_INIT, 8'h20, 32'h12345678);
		prog.get(1'b1, 5'h1F, d);
		check(d, 32'h12345678);
		wr(UPROG_IDX_CUST, 8'hFE, 32'hCAFE0001, 1'b0);
		rd(UPROG_IDX_CUST, 8'hFE, 32'hCAFE0001);
		prog.put(1'b0, 8'h1F, 32'h80000001);
		rd(UPROG_IDX_OUTPUT, 8'h20, 32'h80000001);
		prog.put(1'b1, 8'h00, 32'h00000141);
		rd(UPROG_IDX_DEBUG, 8'h01, 32'h41);
		wr(UPROG_IDX_BOOT, UPROG_BOOT_CMD, 32'h746F6F63, 1'b0);
		watch();
		check(n, 40);
		wr(UPROG_IDX_BOOT, UPROG_BOOT_CMD, UPROG_REBOOT_MAGIC, 1'b0);
		watch();
		check(n, 2);
		wr(UPROG_IDX_BOOT, UPROG_BOOT_DELAY, 32'h2, 1'b0);
		wr(UPROG_IDX_BOOT, UPROG_BOOT_CMD, UPROG_REBOOT_MAGIC, 1'b0);
		watch();
		check(n >= 2 * CPM && n <= 2 * CPM + 4, 1);
		@(posedge clock);
		boot <= 1'b1;
		repeat (2) @(posedge clock);
		#1 check(shrt, 1);
		wr(UPROG_IDX_BOOT, UPROG_BOOT_HWCFG, 32'h1, 1'b0);
		repeat (2) @(posedge clock);
		#1 check(shrt, 0);
		for (int j = 1; j >= 0; j--) begin
			wr(UPROG_IDX_SUBMODE, 8'h00, j, 1'b0);
			repeat (2) @(posedge clock);
			#1 check(smode, j);
			check(loop, j);
		end
		// mid-run reset brings the written input, init, output, storage and reboot command entries back to zero
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rd(UPROG_IDX_INPUT, 8'h05, 32'h0);
		rd(UPROG_IDX_INIT, 8'h20, 32'h0);
		rd(UPROG_IDX_OUTPUT, 8'h20, 32'h0);
		rd(UPROG_IDX_CUST, 8'hFE, 32'h0);
		rd(UPROG_IDX_BOOT, UPROG_BOOT_CMD, 32'h0);
		summarize();
	end
endmodule
bind uprog_bank uprog_bank_monitor mon (.clock(clock), .rst_n(rst_n), .od_req(od_req),
	.od_rsp_r(od_rsp_r), .bootloader_mode(bootloader_mode),
	.windings_short_r(windings_short_r), .reboot_r(reboot_r), .submode_r(submode_r),
	.loop_closed_r(loop_closed_r));
`default_nettype wire
